/* File: shared/svp_regs_defs.vh */
// Register indices and field layout of the test video parameter bank.
// Byte address on the bus is four times a register index; data in bits 7:0.
`ifndef SVP_REGS_DEFS_VH
`define SVP_REGS_DEFS_VH

`define SVP_IDX_W 10
`define SVP_IDX_VSTART_HI 10'h228
`define SVP_IDX_VSTART_LO 10'h229
`define SVP_IDX_HSYNC_HI 10'h22a
`define SVP_IDX_HSYNC_LO 10'h22b
`define SVP_IDX_VSYNC_HI 10'h22c
`define SVP_IDX_VSYNC_LO 10'h22d
`define SVP_IDX_HWIDTH_HI 10'h22e
`define SVP_IDX_HWIDTH_LO 10'h22f
`define SVP_IDX_VHEIGHT_HI 10'h230
`define SVP_IDX_VHEIGHT_LO 10'h231
`define SVP_IDX_FMT0 10'h232
`define SVP_IDX_FMT1 10'h233
`define SVP_IDX_REFRESH 10'h234
`define SVP_IDX_RSVD_FIRST 10'h235
`define SVP_IDX_RSVD_LAST 10'h23f
`define SVP_IDX_CRC_R_LO 10'h240
`define SVP_IDX_CRC_R_HI 10'h241
`define SVP_IDX_CRC_G_LO 10'h242
`define SVP_IDX_CRC_G_HI 10'h243
`define SVP_IDX_CRC_B_LO 10'h244
`define SVP_IDX_CRC_B_HI 10'h245
`define SVP_IDX_CTRL 10'h2f0
`define SVP_IDX_STATUS 10'h2f1

// Control register: bit 0 enables capture of frame CRCs.
`define SVP_CTRL_CRC_EN_BIT 0
`define SVP_CTRL_RESET 1'b1
`define SVP_CTRL_PAD 7'h00

// First format byte layout.
`define SVP_FMT0_SYNC_BIT 0
`define SVP_FMT0_COLOR_LSB 1
`define SVP_FMT0_RANGE_BIT 3
`define SVP_FMT0_COEFF_BIT 4
`define SVP_FMT0_DEPTH_LSB 5
// Second format byte layout; bits 7:2 read zero.
`define SVP_FMT1_DIVISOR_BIT 0
`define SVP_FMT1_INTERLACE_BIT 1

`define SVP_BYTE_ZERO 8'h00
`define SVP_WORD_ZERO 32'h0000_0000
`define SVP_HALF_ZERO 16'h0000
`define SVP_PAD_ZERO 24'h000000
`define SVP_FMT1_PAD 6'h00
`define SVP_CNT_STEP 8'h01

`endif

/* File: verification/svp_crc_src.sv */
// Model of the sink CRC logic that hands frame CRCs to the bank.
// Assumes the bench sets the seed and pulses frame_done itself.
`timescale 1ns/1ps
`default_nettype none
module svp_crc_src (
  // Seed from the bench
  input wire logic [15:0] v,
  // Component CRCs
  output logic [15:0] in_crc_r, in_crc_g, in_crc_b
);
  assign in_crc_r = {v[7:0], v[15:8]};
  assign in_crc_g = ~v;
  assign in_crc_b = v ^ 16'h0ff0;
endmodule // svp_crc_src
`default_nettype wire

/* File: verification/svp_regs_assertions.sv */
// Checker for the APB side of the test video parameter bank.
// Assumes one pclk domain; presetn is asynchronous, active low.
`timescale 1ns/1ps
`default_nettype none
module svp_regs_assertions (
  // Clock and reset
  input wire logic pclk, presetn,
  // APB and block state
  input wire logic psel, penable, pwrite, pready, pslverr, crc_enable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic sp = psel && !penable;
  wire logic rs = sp && !pwrite;
  wire logic cw = pready && pwrite && paddr == 12'hbc0;
  AST_RDY_NEXT: assert property (sp |=> pready) else $error("late ready");
  AST_RDY_PULSE: assert property (pready |=> !pready) else $error("long ready");
  AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray error");
  AST_BYTE: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper");
  AST_RSVD: assert property (rs && paddr inside {[12'h8d4:12'h8fc]} |=> prdata == 32'h0)
    else $error("reserved");
  AST_FMT1: assert property (rs && paddr == 12'h8cc |=> prdata[7:2] == 6'h0)
    else $error("format");
  AST_RO: assert property (sp && pwrite && paddr != 12'hbc0 |=> pslverr) else $error("ro");
  AST_WR_ZERO: assert property (sp && pwrite |=> prdata == 32'h0) else $error("wdata");
  AST_EN: assert property ($changed(crc_enable) |-> $past(cw)) else $error("enable");
  cover property (cw);
  cover property (pslverr);
  cover property ($fell(crc_enable));
endmodule // svp_regs_assertions
bind svp_test_param_regs svp_regs_assertions svp_regs_assertions_inst (.*);
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the test video parameter bank over APB.
// Assumes the checker is bound and the defines header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "svp_regs_defs.vh"
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic param_load = 1'b0, frame_done = 1'b0, pready, pslverr, crc_enable;
  logic in_hsync_pol, in_vsync_pol, in_sync_clock, in_range_select, in_interlaced;
  logic in_conversion_coeff_select, in_refresh_divisor_select;
  logic [1:0] in_color_format;
  logic [2:0] in_bit_depth;
  logic [7:0] in_refresh_numerator;
  logic [11:0] paddr = 12'h000;
  logic [14:0] in_hsync_width, in_vsync_width;
  logic [15:0] v = 16'hb5e3, in_v_start, in_h_width, in_v_height, in_crc_r, in_crc_g, in_crc_b;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_mismatch = 0, checks_done = 0;
  // Bytes at indices 0x228 to 0x245 after one load and one frame with seed b5e3.
  logic [7:0] exp_b [30] = '{8'hb5, 8'he3, 8'h4a, 8'h1c, 8'he3, 8'hb5, 8'hb5, 8'he4, 8'hba,
    8'h13, 8'he3, 8'h01, 8'hb5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hb5, 8'he3, 8'h1c, 8'h4a, 8'h13, 8'hba};
  assign {in_v_start, in_h_width, in_v_height} = {v, v + 16'h0001, v ^ 16'h0ff0};
  assign in_refresh_numerator = v[15:8];
  assign {in_hsync_pol, in_hsync_width, in_vsync_pol, in_vsync_width} = {~v, v[7:0], v[15:8]};
  assign {in_bit_depth, in_conversion_coeff_select, in_range_select, in_color_format,
    in_sync_clock, in_interlaced, in_refresh_divisor_select} = {v[7:0], v[9:8]};
  svp_test_param_regs svp_test_param_regs_inst (.*);
  svp_crc_src svp_crc_src_inst (.*);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Idles one cycle after release so the next request never lands in the same step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic x);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 9; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 9) begin
      n_mismatch++;
      end_of_test;
    end
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, x});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [9:0] i, input logic [7:0] e, input logic x);
    apb(1'b0, {i, 2'h0}, 32'h0, x);
    chk(rd, {24'h0, e});
  endtask
  task automatic strobe(input logic l, input logic f);
    param_load <= l;
    frame_done <= f;
    @(posedge pclk);
    param_load <= 1'b0;
    frame_done <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    strobe(1'b1, 1'b1);
    for (int i = 0; i < 30; i++)
      rdc(10'h228 + i[9:0], exp_b[i], 1'b0);
    apb(1'b1, 12'h8a0, 32'h0000_00ff, 1'b1);
    rdc(`SVP_IDX_VSTART_HI, 8'hb5, 1'b0);
    rdc(10'h3ff, 8'h00, 1'b1);
    apb(1'b1, 12'hbc0, 32'h0, 1'b0);
    chk({31'h0, crc_enable}, 32'h0);
    v <= 16'h4a1c;
    strobe(1'b1, 1'b1);
    rdc(`SVP_IDX_FMT0, 8'h1c, 1'b0);
    rdc(`SVP_IDX_FMT1, 8'h02, 1'b0);
    rdc(`SVP_IDX_CRC_R_LO, 8'hb5, 1'b0);
    apb(1'b1, 12'hbc0, 32'h1, 1'b0);
    strobe(1'b0, 1'b1);
    rdc(`SVP_IDX_CRC_G_HI, 8'hb5, 1'b0);
    rdc(`SVP_IDX_CRC_B_HI, 8'h45, 1'b0);
    rdc(`SVP_IDX_STATUS, 8'h02, 1'b0);
    apb(1'b0, 12'h8a1, 32'h0, 1'b1);
    chk(rd, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`SVP_IDX_VSTART_HI, 8'h00, 1'b0);
    rdc(`SVP_IDX_CTRL, 8'h01, 1'b0);
    rdc(`SVP_IDX_STATUS, 8'h00, 1'b0);
    end_of_test;
  end
endmodule // tb
`default_nettype wire

/* File: verilog/svp_test_param_regs.v */
// Read-only test video parameter bank of a display sink, reached over APB.
// Assumes the sink's test logic supplies parameters with a load pulse and
// frame CRCs with a one-cycle frame-done pulse, all synchronous to pclk.
// Reads are byte-wide in bits 7:0; every register takes one aligned word.
// Only the control register accepts writes; no wait states are inserted.
// The status byte counts captured frames for software bookkeeping.
//
// Overview of operation
// - Vertical active start, high byte first.
// - Hsync polarity bit 7, 15-bit width.
// - Vsync polarity bit 7, 15-bit width.
// - Active width, high byte at lower address.
// - Active height, high byte at lower address.
// - First format byte matches attribute format byte.
// - Bit 0 set when clocks synchronous.
// - Bits 2:1 encode colour format.
// - Bit 3 selects dynamic range.
// - Bit 4 selects conversion coefficients.
// - Bits 7:5 encode component bit depth.
// - Second byte bit 0 selects divisor.
// - Second byte bit 1 flags interlaced.
// - Second byte bits 7:2 read zero.
// - One-byte refresh numerator; reader divides.
// - Reserved range after numerator reads zero.
// - Red/Cr CRC, low byte first.
// - Green/Y CRC, low byte first.
// - Blue/Cb CRC, low byte first.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "svp_regs_defs.vh"

module svp_test_param_regs #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Requested stream parameters from the sink test logic
  input wire param_load,
  input wire [15:0] in_v_start,
  input wire in_hsync_pol,
  input wire [14:0] in_hsync_width,
  input wire in_vsync_pol,
  input wire [14:0] in_vsync_width,
  input wire [15:0] in_h_width,
  input wire [15:0] in_v_height,
  input wire in_sync_clock,
  input wire [1:0] in_color_format,
  input wire in_range_select,
  input wire in_conversion_coeff_select,
  input wire [2:0] in_bit_depth,
  input wire in_refresh_divisor_select,
  input wire in_interlaced,
  input wire [7:0] in_refresh_numerator,
  // Per-component frame CRCs
  input wire frame_done,
  input wire [15:0] in_crc_r,
  input wire [15:0] in_crc_g,
  input wire [15:0] in_crc_b,
  // Block state
  output reg crc_enable
);

  reg [15:0] v_start_q;
  reg [15:0] hsync_q;
  reg [15:0] vsync_q;
  reg [15:0] h_width_q;
  reg [15:0] v_height_q;
  reg [7:0] fmt0_q;
  reg [7:0] fmt1_q;
  reg [7:0] refresh_q;
  reg [15:0] crc_r_q;
  reg [15:0] crc_g_q;
  reg [15:0] crc_b_q;
  reg [7:0] frame_cnt_q;
  reg [7:0] rd_byte_d;
  reg rd_hit_d;
  wire [`SVP_IDX_W-1:0] idx;
  wire aligned;
  wire setup;
  wire wr_done;

  // Next values and decodes shared by several processes.
  wire ctrl_hit;
  wire crc_capture;
  wire [15:0] hsync_d;
  wire [15:0] vsync_d;
  wire [7:0] fmt0_d;
  wire [7:0] fmt1_d;
  reg [31:0] prdata_d;
  reg pslverr_d;

  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel & ~penable;
  assign wr_done = psel & penable & pready & pwrite;
  assign ctrl_hit = aligned && (idx == `SVP_IDX_CTRL);
  assign crc_capture = frame_done & crc_enable;

  // Same packing as the stream's attribute format byte.
  function [7:0] pack_fmt0;
    input sync_clk;
    input [1:0] color;
    input rng;
    input coeff;
    input [2:0] depth;
    begin
      pack_fmt0 = `SVP_BYTE_ZERO;
      pack_fmt0[`SVP_FMT0_SYNC_BIT] = sync_clk;
      pack_fmt0[`SVP_FMT0_COLOR_LSB +: 2] = color;
      pack_fmt0[`SVP_FMT0_RANGE_BIT] = rng;
      pack_fmt0[`SVP_FMT0_COEFF_BIT] = coeff;
      pack_fmt0[`SVP_FMT0_DEPTH_LSB +: 3] = depth;
    end
  endfunction

  assign hsync_d = {in_hsync_pol, in_hsync_width};
  assign vsync_d = {in_vsync_pol, in_vsync_width};
  assign fmt0_d = pack_fmt0(in_sync_clock, in_color_format, in_range_select,
                            in_conversion_coeff_select, in_bit_depth);
  assign fmt1_d = {`SVP_FMT1_PAD, in_interlaced, in_refresh_divisor_select};

  // Parameters are held between load pulses so a read never sees a
  // half-updated request.
  // vertical start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_start_q <= `SVP_HALF_ZERO;
    end else if (param_load) begin
      v_start_q <= in_v_start;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_q <= `SVP_HALF_ZERO;
    end else if (param_load) begin
      hsync_q <= hsync_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsync_q <= `SVP_HALF_ZERO;
    end else if (param_load) begin
      vsync_q <= vsync_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_width_q <= `SVP_HALF_ZERO;
    end else if (param_load) begin
      h_width_q <= in_h_width;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_height_q <= `SVP_HALF_ZERO;
    end else if (param_load) begin
      v_height_q <= in_v_height;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt0_q <= `SVP_BYTE_ZERO;
    end else if (param_load) begin
      fmt0_q <= fmt0_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt1_q <= `SVP_BYTE_ZERO;
    end else if (param_load) begin
      fmt1_q <= fmt1_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_q <= `SVP_BYTE_ZERO;
    end else if (param_load) begin
      refresh_q <= in_refresh_numerator;
    end
  end

  // joint CRC update
  // A frame that ends while capture is off leaves all three CRCs and the
  // count untouched, so the reader always sees one matched set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r_q <= `SVP_HALF_ZERO;
    end else if (crc_capture) begin
      crc_r_q <= in_crc_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_g_q <= `SVP_HALF_ZERO;
    end else if (crc_capture) begin
      crc_g_q <= in_crc_g;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_b_q <= `SVP_HALF_ZERO;
    end else if (crc_capture) begin
      crc_b_q <= in_crc_b;
    end
  end

  // Counts captured frames and wraps; read back as the status byte.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt_q <= `SVP_BYTE_ZERO;
    end else if (crc_capture) begin
      frame_cnt_q <= frame_cnt_q + `SVP_CNT_STEP;
    end
  end

  // Control register: frame CRC capture, on after reset.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_enable <= `SVP_CTRL_RESET;
    end else if (wr_done && ctrl_hit) begin
      crc_enable <= pwdata[`SVP_CTRL_CRC_EN_BIT];
    end
  end

  // Read decode; misaligned or unmapped addresses answer with an error.
  always @* begin
    rd_hit_d = 1'b1;
    rd_byte_d = `SVP_BYTE_ZERO;
    case (idx)
      `SVP_IDX_VSTART_HI: rd_byte_d = v_start_q[15:8];
      `SVP_IDX_VSTART_LO: rd_byte_d = v_start_q[7:0];
      `SVP_IDX_HSYNC_HI: rd_byte_d = hsync_q[15:8];
      `SVP_IDX_HSYNC_LO: rd_byte_d = hsync_q[7:0];
      `SVP_IDX_VSYNC_HI: rd_byte_d = vsync_q[15:8];
      `SVP_IDX_VSYNC_LO: rd_byte_d = vsync_q[7:0];
      `SVP_IDX_HWIDTH_HI: rd_byte_d = h_width_q[15:8];
      `SVP_IDX_HWIDTH_LO: rd_byte_d = h_width_q[7:0];
      `SVP_IDX_VHEIGHT_HI: rd_byte_d = v_height_q[15:8];
      `SVP_IDX_VHEIGHT_LO: rd_byte_d = v_height_q[7:0];
      `SVP_IDX_FMT0: rd_byte_d = fmt0_q;
      `SVP_IDX_FMT1: rd_byte_d = fmt1_q;
      `SVP_IDX_REFRESH: rd_byte_d = refresh_q;
      `SVP_IDX_CRC_R_LO: rd_byte_d = crc_r_q[7:0];
      `SVP_IDX_CRC_R_HI: rd_byte_d = crc_r_q[15:8];
      `SVP_IDX_CRC_G_LO: rd_byte_d = crc_g_q[7:0];
      `SVP_IDX_CRC_G_HI: rd_byte_d = crc_g_q[15:8];
      `SVP_IDX_CRC_B_LO: rd_byte_d = crc_b_q[7:0];
      `SVP_IDX_CRC_B_HI: rd_byte_d = crc_b_q[15:8];
      `SVP_IDX_CTRL: rd_byte_d = {`SVP_CTRL_PAD, crc_enable};
      `SVP_IDX_STATUS: rd_byte_d = frame_cnt_q;
      default: begin
        rd_hit_d = (idx >= `SVP_IDX_RSVD_FIRST) && (idx <= `SVP_IDX_RSVD_LAST);
      end
    endcase
    if (!aligned) begin
      rd_hit_d = 1'b0;
    end
  end

  // Answer is prepared during setup so pready is high in the first access
  // cycle; the bank never inserts wait states.
  always @* begin
    prdata_d = `SVP_WORD_ZERO;
    pslverr_d = 1'b0;
    if (pwrite) begin
      // Writes land only on the control register; all else is read-only.
      pslverr_d = !ctrl_hit;
    end else begin
      pslverr_d = !rd_hit_d;
      if (rd_hit_d) begin
        prdata_d = {`SVP_PAD_ZERO, rd_byte_d};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Read data stays until the next setup; writes and errors return zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `SVP_WORD_ZERO;
    end else if (setup) begin
      prdata <= prdata_d;
    end
  end

  // The error flag is a one-cycle pulse beside pready.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= pslverr_d;
    end else begin
      pslverr <= 1'b0;
    end
  end

endmodule // svp_test_param_regs
`default_nettype wire
